// File: src/cec_regs.svh
// command code, field positions and reset values of the conversion enable configuration byte
`ifndef CEC_REGS_SVH
`define CEC_REGS_SVH
`define CEC_CMD_CODE      8'h02
`define CEC_RSVD_HI       7
`define CEC_RSVD_LO       5
`define CEC_POS_PU        4
`define CEC_POS_CMD       3
`define CEC_POS_CP        2
`define CEC_POS_POL       1
`define CEC_POS_FAST      0
`define CEC_CFG_RESET     5'h00
`define CEC_CNT_RESET     16'h0000
`endif

// File: src/cec_pkg.sv
// types shared by the conversion enable configuration block
`default_nettype none
package cec_pkg;
  typedef struct packed {
    logic powerup_source_select;
    logic cmd_source_select;
    logic pin_source_select;
    logic pin_active_high;
    logic fast_off;
  } cec_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] code;
    logic [7:0] wdata;
  } cec_cmd_t;

  typedef enum logic [1:0] {
    CEC_OFF,
    CEC_ON,
    CEC_HOLD,
    CEC_RAMP
  } cec_state_t;
endpackage : cec_pkg
`default_nettype wire

// File: src/cec_top.sv
// conversion enable configuration: pin and bus enable combination with turn-off profile
`timescale 1ns/1ps
`default_nettype none
`include "cec_regs.svh"
module cec_top (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire cec_pkg::cec_cmd_t bus_cmd,
  input  wire logic             nvm_load,
  input  wire logic [4:0]       nvm_data,
  input  wire logic             clear_faults,
  input  wire logic             run_command,
  input  wire logic             enable_lockout_input,
  input  wire logic             input_power_ok,
  input  wire logic [15:0]      turnoff_hold_time,
  input  wire logic [15:0]      turnoff_ramp_time,
  output logic [7:0]            rd_data_r,
  output logic                  rd_valid_r,
  output logic                  invalid_data_r,
  output logic                  host_alert_r,
  output logic                  conv_en_r,
  output logic                  ramp_active_r,
  output logic                  undervoltage_lockout_r
);
  import cec_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic       pin_s1_r;
  logic       pin_s2_r;
  logic       pwr_s1_r;
  logic       pwr_s2_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= enable_lockout_input;
      pin_s2_r <= pin_s1_r;
      pwr_s1_r <= input_power_ok;
      pwr_s2_r <= pwr_s1_r;
    end
  end

  // ==========================================================
  // configuration byte
  cec_cfg_t   cfg_r;
  logic       wr_hit;
  logic       wr_bad;

  function automatic logic byte_invalid(input logic [7:0] b);
    // only the reserved bits can make a value undefined
    byte_invalid = |b[`CEC_RSVD_HI:`CEC_RSVD_LO];
  endfunction : byte_invalid

  assign wr_hit = bus_cmd.wr && (bus_cmd.code == `CEC_CMD_CODE);
  assign wr_bad = wr_hit && byte_invalid(bus_cmd.wdata);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= `CEC_CFG_RESET;
    end else if (nvm_load) begin
      cfg_r <= nvm_data;
    end else if (wr_hit && !wr_bad) begin
      cfg_r <= bus_cmd.wdata[`CEC_POS_PU:`CEC_POS_FAST];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= bus_cmd.rd && (bus_cmd.code == `CEC_CMD_CODE);
      if (bus_cmd.rd && (bus_cmd.code == `CEC_CMD_CODE)) begin
        rd_data_r <= {3'h0, cfg_r};
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      invalid_data_r <= 1'b0;
      host_alert_r   <= 1'b0;
    end else begin
      invalid_data_r <= wr_bad | (invalid_data_r & ~clear_faults);
      host_alert_r   <= wr_bad | (host_alert_r & ~clear_faults);
    end
  end

  // ==========================================================
  // enable decision
  logic       pin_act;
  logic       pin_ok;
  logic       cmd_ok;
  logic       want_on;
  logic       pin_off;

  assign pin_act = cfg_r.pin_active_high ? pin_s2_r : ~pin_s2_r;
  assign pin_ok  = ~cfg_r.pin_source_select | pin_act;
  assign cmd_ok  = ~cfg_r.cmd_source_select | run_command;
  // with bit 4 clear only input power matters
  assign want_on = pwr_s2_r & (~cfg_r.powerup_source_select | (pin_ok & cmd_ok));
  assign pin_off = cfg_r.powerup_source_select & cfg_r.pin_source_select & ~pin_act;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      undervoltage_lockout_r <= 1'b0;
    end else begin
      // lockout needs a respected, active high pin
      undervoltage_lockout_r <= cfg_r.pin_source_select & cfg_r.pin_active_high;
    end
  end

  // ==========================================================
  // turn-off sequencer
  cec_state_t state_r;
  cec_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      CEC_OFF: begin
        if (want_on) begin
          state_nxt = CEC_ON;
        end
      end
      CEC_ON: begin
        if (!want_on) begin
          if (pwr_s2_r && pin_off && !cfg_r.fast_off) begin
            state_nxt = CEC_HOLD;
            cnt_nxt   = turnoff_hold_time;
          end else begin
            state_nxt = CEC_OFF;
          end
        end
      end
      CEC_HOLD: begin
        if (!pwr_s2_r) begin
          state_nxt = CEC_OFF;
        end else if (cnt_r == `CEC_CNT_RESET) begin
          state_nxt = CEC_RAMP;
          cnt_nxt   = turnoff_ramp_time;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      CEC_RAMP: begin
        // a started ramp runs down to zero unless input power drops first
        if (!pwr_s2_r || cnt_r == `CEC_CNT_RESET) begin
          state_nxt = CEC_OFF;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= CEC_OFF;
      cnt_r   <= `CEC_CNT_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_en_r     <= 1'b0;
      ramp_active_r <= 1'b0;
    end else begin
      conv_en_r     <= (state_nxt != CEC_OFF);
      ramp_active_r <= (state_nxt == CEC_RAMP);
    end
  end

  // ==========================================================
  // checks
  chk_read_zero_hi: assert property (@(posedge clk) disable iff (!rst_n)
    rd_valid_r |-> (rd_data_r[7:5] == 3'h0))
    else $error("reserved bits read nonzero");

  chk_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_cmd.rd && bus_cmd.code == 8'h02) |=> (rd_valid_r && rd_data_r[4:0] == $past(cfg_r)))
    else $error("read does not return config");

  chk_write_takes: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_hit && !wr_bad && !nvm_load) |=> (cfg_r == $past(bus_cmd.wdata[4:0])))
    else $error("valid write not applied");

  chk_bad_write_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_bad && !nvm_load) |=> ($stable(cfg_r) && invalid_data_r && host_alert_r))
    else $error("invalid write not flagged");

  chk_powerup_free: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == CEC_OFF && !cfg_r.powerup_source_select && pwr_s2_r) |=> conv_en_r)
    else $error("no start with power present");

  chk_cmd_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == CEC_OFF && cfg_r.powerup_source_select && !cfg_r.cmd_source_select
     && !cfg_r.pin_source_select && pwr_s2_r) |=> conv_en_r)
    else $error("run command not disregarded");

  chk_fast_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == CEC_ON && pin_off && cfg_r.fast_off) |=> !conv_en_r)
    else $error("fast off not immediate");

  chk_hold_then_ramp: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == CEC_ON && !want_on && pwr_s2_r && pin_off && !cfg_r.fast_off && turnoff_hold_time == 16'h0002)
    |=> (conv_en_r && !ramp_active_r) [*3] ##1 ramp_active_r)
    else $error("hold time not kept before ramp");

  chk_lockout: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_r.pin_active_high |=> !undervoltage_lockout_r)
    else $error("lockout with active low pin");

  chk_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_bad && clear_faults) |=> invalid_data_r)
    else $error("clear beat set");
endmodule : cec_top
`default_nettype wire

// File: tb/cec_host_model.sv
// pmbus host and enable pin driver facing the configuration block
`timescale 1ns/1ps
`default_nettype none
module cec_host_model (
  input  wire logic           clk,
  output var cec_pkg::cec_cmd_t bus_cmd,
  output var logic            pin
);
  import cec_pkg::*;
  initial begin
    bus_cmd = '0;
    pin = 1'b0;
  end
  // ====================
  // transfers
  // released strobes are cleared and code and data inverted so nothing stale looks valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    bus_cmd <= '{wr: w, rd: !w, code: c, wdata: d};
    @(posedge clk);
    bus_cmd <= '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: ~d};
  endtask : xfer
  task automatic set_pin(input logic v);
    pin <= v;
  endtask : set_pin
endmodule : cec_host_model
`default_nettype wire

// File: tb/cec_top_tb.sv
// self-checking bench for the conversion enable configuration block
`timescale 1ns/1ps
`default_nettype none
`include "cec_regs.svh"
module cec_top_tb;
  import cec_pkg::*;
  logic        clk, rst_n, nvm_load, clear_faults, run_command, pwr_ok;
  logic [4:0]  nvm_data, cfg;
  logic [15:0] hold_t, ramp_t;
  cec_cmd_t    bus_cmd;
  logic        pin, rd_valid, inv, alert, conv_en, ramp, undervoltage_lockout;
  logic [7:0]  rd_data;
  logic [7:0]  exp_q[$];
  int          err_count, checked, cycles, seed;
  // fields: config, power, run, pin, expected enable
  logic [8:0]  tbl [11] = '{9'h009, 9'h006, 9'h19D, 9'h19A, 9'h119, 9'h17B,
                            9'h17C, 9'h159, 9'h15A, 9'h1DD, 9'h1DA};
  cec_host_model host_u (.clk(clk), .bus_cmd(bus_cmd), .pin(pin));
  cec_top dut_u (.clk(clk), .rst_n(rst_n), .bus_cmd(bus_cmd), .nvm_load(nvm_load),
    .nvm_data(nvm_data), .clear_faults(clear_faults), .run_command(run_command),
    .enable_lockout_input(pin), .input_power_ok(pwr_ok), .turnoff_hold_time(hold_t),
    .turnoff_ramp_time(ramp_t), .rd_data_r(rd_data), .rd_valid_r(rd_valid),
    .invalid_data_r(inv), .host_alert_r(alert), .conv_en_r(conv_en),
    .ramp_active_r(ramp), .undervoltage_lockout_r(undervoltage_lockout));
  // ====================
  // checking
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, `CEC_CMD_CODE, 8'h00);
  endtask : rd
  task automatic wr_lvl(input logic [4:0] c, input logic p, input logic r, input logic n);
    host_u.xfer(1'b1, `CEC_CMD_CODE, {3'h0, c});
    pwr_ok <= p;
    run_command <= r;
    host_u.set_pin(n);
    repeat (12) @(posedge clk);
  endtask : wr_lvl
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // answers are matched against the oldest note; an unexpected answer fails
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
    if (exp_q.size() == 0) check(rd_valid, 1'b0);
    else if (rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
  end
  // ====================
  // scenarios
  initial begin
    {rst_n, nvm_load, clear_faults, run_command, pwr_ok, nvm_data} = '0;
    {err_count, checked, cycles} = '0;
    seed = 10482;
    hold_t = 16'h0002;
    ramp_t = 16'h0003;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00);
    repeat (6) begin
      cfg = 5'($random(seed));
      host_u.xfer(1'b1, `CEC_CMD_CODE, {3'h0, cfg});
      rd({3'h0, cfg});
    end
    // clear held across the bad write: the set must win
    clear_faults <= 1'b1;
    host_u.xfer(1'b1, `CEC_CMD_CODE, {3'h5, cfg});
    clear_faults <= 1'b0;
    @(posedge clk);
    check({inv, alert}, 8'h03);
    rd({3'h0, cfg});
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    host_u.xfer(1'b0, 8'h03, 8'h00);
    repeat (2) @(posedge clk);
    check({inv, alert}, 8'h00);
    nvm_data <= 5'h15;
    nvm_load <= 1'b1;
    @(posedge clk);
    nvm_load <= 1'b0;
    rd(8'h15);
    check(undervoltage_lockout, 1'b0);
    foreach (tbl[i]) begin
      wr_lvl(tbl[i][8:4], tbl[i][3], tbl[i][2], tbl[i][1]);
      check(conv_en, tbl[i][0]);
    end
    wr_lvl(5'h17, 1'b1, 1'b0, 1'b1);
    check(undervoltage_lockout, 1'b1);
    host_u.set_pin(1'b0);
    repeat (5) @(posedge clk);
    check(conv_en, 1'b0);
    wr_lvl(5'h16, 1'b1, 1'b0, 1'b1);
    host_u.set_pin(1'b0);
    repeat (8) @(posedge clk);
    check({conv_en, ramp}, 8'h03);
    repeat (8) @(posedge clk);
    check({conv_en, ramp}, 8'h00);
    finish_test();
  end
endmodule : cec_top_tb
`default_nettype wire
